// ### shared/iap_pkg.sv
package iap_pkg;
   // Register select codes on the special function register port
   localparam logic [3:0] sel_ctrl = 4'h0;
   localparam logic [3:0] sel_addr_low = 4'h1;
   localparam logic [3:0] sel_addr_high = 4'h2;
   localparam logic [3:0] sel_word_base = 4'h8;
   // Control register fields
   localparam int enabled_bit = 7;
   localparam int mode_lsb = 4;
   localparam int unlock_bit = 3;
   localparam int write_bit = 2;
   localparam int read_en_bit = 1;
   localparam int read_bit = 0;
   localparam logic [7:0] ctrl_reset = 8'h70;
   localparam logic [7:0] data_reset = 8'h00;
   localparam logic [7:0] high_mask = 8'h7f;
   // Mode encodings
   localparam logic [2:0] mode_write = 3'h0;
   localparam logic [2:0] mode_erase = 3'h1;
   localparam logic [2:0] mode_read = 3'h3;
   localparam logic [2:0] mode_unlock = 3'h6;
   // Unlock pattern, byte 0 goes to word 1 low
   localparam logic [47:0] unlock_pattern = 48'h40c3090d0400;
   // Timeout on the low-speed oscillator
   localparam int timeout_us = 300;
   localparam int osc_khz = 32;
   localparam int timeout_ticks = (timeout_us * osc_khz) / 1000;
   // Erase geometry
   localparam int block_words = 256;
   localparam int small_page_words = 32;
   localparam int large_page_words = 64;
   typedef struct packed {
      logic [3:0] sel;
      logic wr;
      logic [7:0] wdata;
   } sfr_req_t;
endpackage

// ### rtl/iap_word_regs.sv
// Eight data byte registers of four 16-bit words
module iap_word_regs
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Write and read
   input wire logic wr,
   input wire logic [2:0] idx,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic [63:0] words
);
   logic [7:0] mem_reg [8];
   // Byte storage, reset to zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 8; i++)
            mem_reg[i] <= iap_pkg::data_reset;
      end
      else if (ce && wr)
         mem_reg[idx] <= wdata;
   end
   // Registered read data
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rdata <= iap_pkg::data_reset;
      else if (ce)
         rdata <= mem_reg[idx];
   end
   // Flat view of all bytes
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         words[i*8 +: 8] = mem_reg[i];
   end
endmodule

// ### rtl/iap_timeout.sv
// Unlock timeout counter on low-speed oscillator ticks
module iap_timeout
#(
   parameter int ticks = iap_pkg::timeout_ticks
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic start,
   input wire logic stop,
   input wire logic tick,
   output logic overflow
);
   logic [15:0] count_reg;
   logic run_reg;
   // Counts ticks while running, pulses overflow once
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         count_reg <= 16'h0000;
         run_reg <= 1'b0;
         overflow <= 1'b0;
      end
      else if (ce)
      begin
         overflow <= 1'b0;
         if (start)
         begin
            count_reg <= 16'h0000;
            run_reg <= 1'b1;
         end
         else if (stop)
            run_reg <= 1'b0;
         else if (run_reg && tick)
         begin
            if (count_reg == 16'(ticks - 1))
            begin
               overflow <= 1'b1;
               run_reg <= 1'b0;
            end
            else
               count_reg <= count_reg + 16'h0001;
         end
      end
   end
endmodule

// ### rtl/iap_unlock.sv
// Flash programming front end: address, data words, unlock and erase addressing
module iap_unlock
#(
   parameter int page_words = iap_pkg::large_page_words,
   parameter bit block_erase = 1'b0,
   parameter int ticks = iap_pkg::timeout_ticks
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input iap_pkg::sfr_req_t req,
   output logic [7:0] rdata,
   // Low-speed oscillator from outside the clock domain
   input wire logic low_speed_internal_osc,
   // Flash macro handshake
   input wire logic write_done,
   output logic write_go,
   output logic erase_go,
   output logic write_enabled,
   output logic [14:0] erase_addr
);
   logic [7:0] ctrl_reg;
   logic [7:0] addr_low_reg;
   logic [7:0] addr_high_reg;
   logic [63:0] words;
   logic [5:0] seen_reg;
   logic [1:0] osc_sync_reg;
   logic osc_last_reg;
   logic osc_tick;
   logic overflow;
   logic start;
   logic last_byte;
   logic [2:0] sel_idx;
   logic is_word;
   logic ctrl_wr;
   logic [7:0] ctrl_next;

   typedef enum {idle, armed} unlock_state_t;
   unlock_state_t state_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Erase page number from the address registers
   function automatic logic [14:0] page_of(input logic [7:0] hi, input logic [7:0] lo);
      logic [14:0] n;
      n = 15'h0000;
      if (block_erase)
         n = {11'h000, hi[3:0]};
      else if (page_words == iap_pkg::small_page_words)
         n = {4'h0, hi, lo[7:5]};
      else
         n = {5'h00, hi, lo[7:6]};
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode of register port
   assign is_word = req.sel[3];
   assign sel_idx = req.sel[2:0];
   assign ctrl_wr = req.wr && req.sel == iap_pkg::sel_ctrl;
   assign start = ctrl_wr && req.wdata[iap_pkg::unlock_bit]
      && req.wdata[iap_pkg::mode_lsb +: 3] == iap_pkg::mode_unlock;
   assign last_byte = state_reg == armed && req.wr && is_word && sel_idx == 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Two-stage sync of oscillator and tick detect
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         osc_sync_reg <= 2'b00;
         osc_last_reg <= 1'b0;
      end
      else if (ce)
      begin
         osc_sync_reg <= {osc_sync_reg[0], low_speed_internal_osc};
         osc_last_reg <= osc_sync_reg[1];
      end
   end
   assign osc_tick = osc_sync_reg[1] && !osc_last_reg;

   iap_timeout #(.ticks(ticks)) timer
   (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .start(start),
      .stop(state_reg == armed && last_byte),
      .tick(osc_tick),
      .overflow(overflow)
   );

   iap_word_regs words_u
   (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .wr(req.wr && is_word),
      .idx(sel_idx),
      .wdata(req.wdata),
      .rdata(),
      .words(words)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Track which unlock bytes were written during the attempt
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         seen_reg <= 6'h00;
      else if (ce)
      begin
         if (start)
            seen_reg <= 6'h00;
         else if (state_reg == armed && req.wr && is_word && sel_idx >= 3'h2)
            seen_reg[sel_idx - 3'h2] <= 1'b1;
      end
   end

   // Unlock state machine
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         state_reg <= idle;
      else if (ce)
      begin
         case (state_reg)
            idle:
               if (start)
                  state_reg <= armed;
            armed:
               if (overflow || last_byte)
                  state_reg <= idle;
            default:
               state_reg <= idle;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register next value
   always_comb
   begin
      logic [47:0] pat;
      pat = {req.wdata, words[55:16]}; // Bytes of word 1 low to word 3 low, then the last byte
      ctrl_next = ctrl_reg;
      if (ctrl_wr)
      begin
         // Enabled flag: software may only clear it
         ctrl_next = {ctrl_reg[iap_pkg::enabled_bit] & req.wdata[iap_pkg::enabled_bit],
            req.wdata[6:0]};
         if (!ctrl_reg[iap_pkg::enabled_bit] && req.wdata[iap_pkg::mode_lsb +: 3] == iap_pkg::mode_write)
            ctrl_next[iap_pkg::write_bit] = 1'b0;
      end
      if (state_reg == armed && overflow)
         ctrl_next[iap_pkg::unlock_bit] = 1'b0;
      if (last_byte)
      begin
         ctrl_next[iap_pkg::unlock_bit] = 1'b0;
         if (pat == iap_pkg::unlock_pattern && seen_reg[4:0] == 5'h1f && !overflow)
            ctrl_next[iap_pkg::enabled_bit] = 1'b1;
      end
      if (write_done)
         ctrl_next[iap_pkg::write_bit] = 1'b0;
   end

   // Control register
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ctrl_reg <= iap_pkg::ctrl_reset;
      else if (ce)
         ctrl_reg <= ctrl_next;
   end

   // Address registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         addr_low_reg <= iap_pkg::data_reset;
         addr_high_reg <= iap_pkg::data_reset;
      end
      else if (ce && req.wr)
      begin
         if (req.sel == iap_pkg::sel_addr_low)
            addr_low_reg <= req.wdata;
         if (req.sel == iap_pkg::sel_addr_high)
            addr_high_reg <= req.wdata & iap_pkg::high_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered read mux; word bytes come from the flat view so every select answers one cycle later
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rdata <= 8'h00;
      else if (ce)
      begin
         case (req.sel)
            iap_pkg::sel_ctrl: rdata <= ctrl_reg;
            iap_pkg::sel_addr_low: rdata <= addr_low_reg;
            iap_pkg::sel_addr_high: rdata <= addr_high_reg;
            default: rdata <= is_word ? words[sel_idx*8 +: 8] : 8'h00;
         endcase
      end
   end

   // Flash operation strobes, gated by the write enable
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         write_go <= 1'b0;
         erase_go <= 1'b0;
         write_enabled <= 1'b0;
         erase_addr <= 15'h0000;
      end
      else if (ce)
      begin
         write_enabled <= ctrl_reg[iap_pkg::enabled_bit];
         write_go <= ctrl_reg[iap_pkg::enabled_bit] && ctrl_reg[iap_pkg::write_bit]
            && ctrl_reg[iap_pkg::mode_lsb +: 3] == iap_pkg::mode_write;
         erase_go <= ctrl_reg[iap_pkg::enabled_bit] && ctrl_reg[iap_pkg::write_bit]
            && ctrl_reg[iap_pkg::mode_lsb +: 3] == iap_pkg::mode_erase;
         erase_addr <= page_of(addr_high_reg, addr_low_reg);
      end
   end
endmodule

// ### tb/iap_unlock_props.sv
// Checker on the programming front end ports
module iap_unlock_props
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Watched ports
   input iap_pkg::sfr_req_t req,
   input wire logic [7:0] rdata,
   input wire logic write_done,
   input wire logic write_go,
   input wire logic erase_go,
   input wire logic write_enabled
);
   logic last_wr;
   logic ctrl_wr;
   logic [2:0] since_reg;
   // Decoded register writes
   assign last_wr = ce && req.wr && req.sel == 4'hf;
   assign ctrl_wr = ce && req.wr && req.sel == iap_pkg::sel_ctrl;
   // Cycles since the last pattern byte, saturating
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         since_reg <= 3'h7;
      else if (last_wr)
         since_reg <= 3'h0;
      else if (since_reg != 3'h7)
         since_reg <= since_reg + 3'h1;
   ////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_enable_after_last: assert property ($rose(write_enabled) |-> since_reg <= 3'h3)
      else $error("enable flag rose without a final pattern byte");
   a_flag_one_ignored: assert property (ctrl_wr && req.wdata[7] && !write_enabled && since_reg == 3'h7
      |=> !write_enabled ##1 !write_enabled)
      else $error("writing one set the enable flag");
   a_clear_disables: assert property (write_enabled && ctrl_wr && !req.wdata[7] && since_reg == 3'h7
      |-> ##[1:2] !write_enabled)
      else $error("clearing the enable flag left writing on");
   a_go_needs_enable: assert property (write_go |-> write_enabled || $past(write_enabled))
      else $error("write started while disabled");
   a_erase_needs_enable: assert property (erase_go |-> write_enabled || $past(write_enabled))
      else $error("erase started while disabled");
   a_go_holds: assert property (write_go && !write_done && !$past(write_done) && !ctrl_wr && !$past(ctrl_wr)
      |=> write_go)
      else $error("write start dropped before completion");
   a_done_drops_go: assert property (write_go && write_done |-> ##[1:2] !write_go)
      else $error("write start not cleared by completion");
   a_high_bit_zero: assert property (ce && req.sel == iap_pkg::sel_addr_high |=> rdata[7] == 1'b0)
      else $error("high address bit 7 read as one");
endmodule
bind iap_unlock iap_unlock_props u_props (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
   .write_done(write_done), .write_go(write_go), .erase_go(erase_go), .write_enabled(write_enabled));

// ### tb/iap_unlock_test.sv
module iap_unlock_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ticks = 9;
   logic mclk;
   logic rst;
   logic ce;
   logic osc_clk = 1'b0;
   logic write_done;
   iap_pkg::sfr_req_t req;
   logic [7:0] rdata;
   logic write_go;
   logic erase_go;
   logic write_enabled;
   logic [14:0] erase_addr;
   logic [14:0] erase_addr_small;
   logic [14:0] erase_addr_block;
   int miscompares = 0;
   int checks = 0;
   int seed;
   int osc_cnt = 0;
   logic [7:0] v;
   logic [7:0] hi;
   logic [7:0] lo;
   byte unsigned pat[$] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
   iap_unlock #(.page_words(iap_pkg::large_page_words), .block_erase(1'b0), .ticks(ticks)) u_dut (.mclk(mclk),
      .rst(rst), .ce(ce), .req(req), .rdata(rdata), .low_speed_internal_osc(osc_clk),
      .write_done(write_done), .write_go(write_go), .erase_go(erase_go), .write_enabled(write_enabled),
      .erase_addr(erase_addr));
   // Small page and block erase variants see the same stimulus
   iap_unlock #(.page_words(iap_pkg::small_page_words), .block_erase(1'b0), .ticks(ticks)) u_dut_small
      (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .rdata(), .low_speed_internal_osc(osc_clk),
      .write_done(write_done), .write_go(), .erase_go(), .write_enabled(), .erase_addr(erase_addr_small));
   iap_unlock #(.page_words(iap_pkg::large_page_words), .block_erase(1'b1), .ticks(ticks)) u_dut_block
      (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .rdata(), .low_speed_internal_osc(osc_clk),
      .write_done(write_done), .write_go(), .erase_go(), .write_enabled(), .erase_addr(erase_addr_block));
   // Main clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Slow oscillator, twenty main cycles a period
   always @(posedge mclk)
   begin
      osc_cnt <= (osc_cnt + 1) % 20;
      osc_clk <= osc_cnt < 10;
   end
   ////////////////////////////////////////
   task automatic conclude();
      if (miscompares == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [14:0] exp, input logic [14:0] got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] sel, input logic [7:0] d);
      req <= '{sel, 1'b1, d};
      @(posedge mclk);
   endtask
   task automatic idle(input int n);
      req.wr <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] sel);
      req <= '{sel, 1'b0, 8'h00};
      @(posedge mclk);
      @(negedge mclk);
      v = rdata;
      @(posedge mclk);
   endtask
   // Waits for a start strobe to reach the expected level, bounded
   task automatic wait_go(input bit erase, input logic exp);
      int n;
      n = 0;
      req.wr <= 1'b0;
      @(negedge mclk);
      while ((erase ? erase_go : write_go) !== exp && n < 8)
      begin
         @(negedge mclk);
         n++;
      end
      cmp("start strobe", {14'h0, exp}, {14'h0, erase ? erase_go : write_go});
      if (n == 8)
         conclude();
      @(posedge mclk);
   endtask
   task automatic done_pulse(input bit erase);
      write_done <= 1'b1;
      @(posedge mclk);
      write_done <= 1'b0;
      wait_go(erase, 1'b0);
   endtask
   // Unlock attempt: n bytes, byte bad spoiled by flip
   task automatic unlock(input int bad, input logic [7:0] flip, input int n);
      wr(iap_pkg::sel_ctrl, {1'b0, iap_pkg::mode_unlock, 4'h8});
      for (int i = 0; i < n; i++)
         wr(iap_pkg::sel_word_base + 4'h2 + i[3:0], pat[i] ^ (i == bad ? flip : 8'h00));
      idle(3);
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      conclude();
   end
   // Main sequence
   initial
   begin
      seed = 87662;
      rst = 1'b1;
      ce = 1'b1;
      write_done = 1'b0;
      req = '0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd(iap_pkg::sel_ctrl);
      cmp("ctrl", iap_pkg::ctrl_reset, v);
      for (int s = 8; s < 16; s++)
      begin
         rd(s[3:0]);
         cmp("word byte", 15'h0, v);
      end
      hi = $random(seed);
      wr(iap_pkg::sel_addr_high, hi | 8'h80);
      rd(iap_pkg::sel_addr_high);
      cmp("addr_high", (hi | 8'h80) & iap_pkg::high_mask, v);
      lo = $random(seed);
      wr(iap_pkg::sel_word_base, lo);
      rd(iap_pkg::sel_word_base);
      cmp("word0 low", {7'h0, lo}, v);
      // Clock enable low must drop a write
      ce <= 1'b0;
      wr(iap_pkg::sel_addr_low, lo | 8'h01);
      idle(2);
      ce <= 1'b1;
      rd(iap_pkg::sel_addr_low);
      cmp("addr_low frozen", 15'h0, v);
      wr(iap_pkg::sel_ctrl, 8'h80);
      rd(iap_pkg::sel_ctrl);
      cmp("ctrl", 15'h0, v);
      wr(iap_pkg::sel_ctrl, 8'h04);
      idle(4);
      cmp("write_go", 15'h0, write_go);
      for (int b = 0; b < 6; b++)
      begin
         lo = $random(seed);
         unlock(b, lo | 8'h01, 6);
         rd(iap_pkg::sel_ctrl);
         cmp("ctrl", 15'h60, v);
         cmp("write_enabled", 15'h0, write_enabled);
      end
      unlock(6, 8'h00, 5);
      rd(iap_pkg::sel_ctrl);
      cmp("ctrl", 15'h68, v);
      idle(100);
      rd(iap_pkg::sel_ctrl);
      cmp("ctrl", 15'h68, v);
      idle(150);
      rd(iap_pkg::sel_ctrl);
      cmp("ctrl", 15'h60, v);
      wr(4'hf, 8'h40);
      idle(3);
      cmp("write_enabled", 15'h0, write_enabled);
      unlock(6, 8'h00, 6);
      rd(iap_pkg::sel_ctrl);
      cmp("ctrl", 15'he0, v);
      cmp("write_enabled", 15'h1, write_enabled);
      wr(iap_pkg::sel_ctrl, 8'h84);
      wait_go(1'b0, 1'b1);
      idle(5);
      cmp("write_go", 15'h1, write_go);
      done_pulse(1'b0);
      rd(iap_pkg::sel_ctrl);
      cmp("ctrl", 15'h80, v);
      hi = $random(seed);
      lo = $random(seed);
      wr(iap_pkg::sel_addr_high, hi);
      wr(iap_pkg::sel_addr_low, lo);
      wr(iap_pkg::sel_ctrl, 8'h94);
      wait_go(1'b1, 1'b1);
      cmp("erase_addr", {6'h0, hi[6:0], lo[7:6]}, erase_addr);
      cmp("erase_addr small", {5'h0, hi[6:0], lo[7:5]}, erase_addr_small);
      cmp("erase_addr block", {11'h0, hi[3:0]}, erase_addr_block);
      done_pulse(1'b1);
      wr(iap_pkg::sel_ctrl, 8'hb4);
      idle(4);
      cmp("go", 15'h0, {13'h0, write_go, erase_go});
      wr(iap_pkg::sel_ctrl, 8'h00);
      idle(3);
      cmp("write_enabled", 15'h0, write_enabled);
      wr(iap_pkg::sel_ctrl, 8'h04);
      idle(4);
      cmp("write_go", 15'h0, write_go);
      conclude();
   end
endmodule
